// [bench/sfr_host.sv]
// bus host model: select, serial clock, request lanes, read bytes
`timescale 1ns/10ps
module sfr_host (
	input wire logic [3:0] io_i,
	output logic cs_n_o,
	output logic sck_o,
	output logic [3:0] hd_o,
	output logic [3:0] hoe_o
);
	logic [7:0] rx[$];
	// clock idles low between frames, mode 0
	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		hd_o = 4'h0;
		hoe_o = 4'h0;
	end
	// one serial clock: lanes change at the fall, sampled at the rise
	task automatic tick(input logic [3:0] d, input logic [3:0] oe,
		output logic [3:0] s);
		hd_o = d;
		hoe_o = oe;
		#80;
		s = io_i;
		sck_o = 1'b1;
		#80;
		sck_o = 1'b0;
	endtask
	// one frame; n data clocks, may stop in mid-byte
	task automatic frame(input logic [7:0] op, input bit cmd,
		input logic [23:0] a, input int aw, input int dum,
		input logic [7:0] m, input int w, input int n);
		logic [3:0] s;
		logic [7:0] acc;
		int k;
		int nb;
		rx.delete();
		nb = 0;
		acc = 8'h0;
		cs_n_o = 1'b0;
		if (cmd)
			for (k = 7; k >= 0; k--) tick({3'h0, op[k]}, 4'h1, s);
		for (k = 24 - aw; k >= 0; k -= aw)
			tick(aw == 4 ? a[k+:4] : {3'h0, a[k]}, aw == 4 ? 4'hf : 4'h1, s);
		for (k = 0; k < dum; k++)
			tick(k == 0 ? m[7:4] : m[3:0], k < 2 && aw == 4 ? 4'hf : 4'h0, s);
		// lanes released for data; same clock rate for all opcodes
		for (k = 0; k < n; k++) begin
			tick(4'h0, 4'h0, s);
			acc = w == 1 ? {acc[6:0], s[1]} : w == 2 ? {acc[5:0], s[1:0]}
				: {acc[3:0], s};
			nb += w;
			if (nb == 8) begin
				rx.push_back(acc);
				nb = 0;
			end
		end
		cs_n_o = 1'b1;
		#400;
	endtask
endmodule

// [bench/sfr_read_path_monitor.sv]
// checker of the read path pins and array port
`timescale 1ns/10ps
`include "sfr_regs.svh"
module sfr_read_path_monitor (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic [3:0] io_i,
	input wire logic [3:0] io_o,
	input wire logic [3:0] io_oe_o,
	input wire logic four_lane_enable_bit_i,
	input wire logic word_aligned_addressing_i,
	input wire logic [3:0] xip_dummy_clks_i,
	input wire logic [`SFR_ARRAY_AW-1:0] mem_addr_o,
	input wire logic [7:0] mem_data_i,
	input wire logic execute_in_place_read_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// select has been high long enough for the pins to let go
	sequence cs_idle_s;
		cs_n_i [*5];
	endsequence
	// array address moved while data was already on the pins
	sequence addr_step_s;
		$changed(mem_addr_o) && $past(|io_oe_o);
	endsequence
	pins_float_a: assert property (cs_idle_s |-> io_oe_o == 4'h0)
		else $error("pins driven while deselected");
	drive_in_frame_a: assert property (|io_oe_o |-> !$past(cs_n_i, 5))
		else $error("pins driven outside a frame");
	lane_shape_a: assert property (io_oe_o inside {4'h0, 4'h2, 4'h3, 4'hf})
		else $error("illegal set of driven pins");
	enable_hold_a: assert property ($changed(io_oe_o)
		|-> $past(io_oe_o) == 4'h0 || cs_n_i) else $error("enables moved");
	addr_inc_a: assert property (addr_step_s
		|-> mem_addr_o == $past(mem_addr_o) + 1'b1) else $error("bad step");
	addr_gap_a: assert property (addr_step_s
		|=> $stable(mem_addr_o) [*8]) else $error("bytes too close");
	out_on_fall_a: assert property ($changed(io_o & io_oe_o) |-> !sck_i)
		else $error("data changed while clock high");
	armed_in_frame_a: assert property ($changed(execute_in_place_read_o)
		|-> !cs_n_i) else $error("armed state moved outside frame");
endmodule
bind sfr_read_path sfr_read_path_monitor u_mon (.core_clk_i, .rst_n_i, .cs_n_i,
	.sck_i, .io_i, .io_o, .io_oe_o, .four_lane_enable_bit_i,
	.word_aligned_addressing_i, .xip_dummy_clks_i, .mem_addr_o, .mem_data_i,
	.execute_in_place_read_o);

// [bench/tb.sv]
// self-checking bench of the read path against an array model
`timescale 1ns/10ps
`include "sfr_regs.svh"
`define CHK(NM, EX, GT) begin checked++; if ((GT) !== (EX)) begin \
	miscompares++; $display("[FAIL] %s exp %h got %h", NM, EX, GT); end end
module tb;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic cs_n, sck, fle, wa, armed, seen_oe;
	logic tog = 1'b0;
	logic [3:0] io_i, io_o, io_oe_o, hd, hoe, xd;
	logic [`SFR_ARRAY_AW-1:0] mem_addr;
	logic [7:0] mem_data;
	logic [31:0] seed = 32'h634ac141;
	int miscompares = 0;
	int checked = 0;
	function automatic logic [7:0] mem_f(input logic [21:0] a);
		return a[7:0] ^ a[15:8] ^ {a[21:16], 2'b10};
	endfunction
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	always #10 core_clk_i = ~core_clk_i;
	// released lanes float: a toggling level so no stale bit passes
	always @(posedge core_clk_i) begin
		tog <= #1 ~tog;
		if (|io_oe_o) seen_oe <= 1'b1;
	end
	assign io_i = (io_oe_o & io_o) | (~io_oe_o & ((hoe & hd) | (~hoe & {4{tog}})));
	assign mem_data = mem_f(mem_addr);
	sfr_read_path u_dut (.core_clk_i, .rst_n_i, .cs_n_i(cs_n), .sck_i(sck),
		.io_i, .io_o, .io_oe_o, .four_lane_enable_bit_i(fle),
		.word_aligned_addressing_i(wa), .xip_dummy_clks_i(xd),
		.mem_addr_o(mem_addr), .mem_data_i(mem_data),
		.execute_in_place_read_o(armed));
	sfr_host u_host (.io_i(io_i), .cs_n_o(cs_n), .sck_o(sck), .hd_o(hd),
		.hoe_o(hoe));
	task automatic results();
		if (miscompares == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// one read: n whole bytes plus x spare clocks, compared with the model
	task automatic rd(input logic [7:0] op, input bit cmd, input logic [23:0] a,
		input int n, input logic [7:0] m, input int x);
		int w, aw, dum, i, nt;
		logic [21:0] p;
		w = op == 8'h3b ? 2 : (op == 8'h03 || op == 8'h0b) ? 1 : 4;
		aw = (op == 8'heb || op == 8'he7) ? 4 : 1;
		dum = op == 8'h03 ? 0 : aw == 4 ? int'(xd) : 8;
		p = a[21:0];
		if (op == 8'he7 || (op == 8'heb && wa)) p[1:0] = 2'b00;
		seen_oe = 1'b0;
		// data clocks sent; whole bytes the host assembles from them
		nt = n * 8 / w + x;
		u_host.frame(op, cmd, a, aw, dum, m, w, nt);
		`CHK("bytes", nt * w / 8, u_host.rx.size())
		for (i = 0; i < n; i++)
			`CHK("data", mem_f(22'(p + i)), u_host.rx[i])
		`CHK("drive", !(op == 8'h6b && !fle), seen_oe)
		if (aw == 4) `CHK("armed", m[5:4] == 2'b10, armed)
	endtask
	initial begin
		fle = 1'b1;
		wa = 1'b0;
		xd = 4'h4;
		seen_oe = 1'b0;
		repeat (4) @(posedge core_clk_i);
		#1 rst_n_i = 1'b1;
		repeat (4) @(posedge core_clk_i);
		#1;
		rd(8'h03, 1, 24'h3ffffe, 4, 8'h0, 0);
		rd(8'h0b, 1, 24'(rnd()), 3, 8'h0, 3);
		rd(8'h3b, 1, 24'(rnd()), 3, 8'h0, 1);
		rd(8'h6b, 1, 24'(rnd()), 3, 8'h0, 1);
		fle = 1'b0;
		rd(8'h6b, 1, 24'(rnd()), 0, 8'h0, 16);
		fle = 1'b1;
		for (int i = 0; i < 4; i++) begin
			wa = i[0];
			xd = 4'h2 + 4'(rnd() % 8);
			rd(i < 2 ? 8'heb : 8'he7, 1, 24'(rnd()), 2, i == 3 ? 8'h20 : 8'h0,
				0);
		end
		rd(8'he7, 0, 24'h3ffffd, 6, 8'h0, 1);
		results();
	end
	// hang guard
	initial begin
		#1ms;
		miscompares++;
		results();
	end
endmodule

// [src/sfr_lane_mux.sv]
// maps the top bits of the outgoing byte onto the four data pins
`timescale 1ns/10ps
module sfr_lane_mux
	import sfr_pkg::*;
(
	input sfr_pkg::sfr_width_t width_i,
	input wire logic [7:0] shift_i,
	output logic [3:0] io_o
);
	import sfr_pkg::*;

	// pin order: 0 serial in, 1 serial out, 2 write protect, 3 pause
	always_comb begin
		io_o = 4'h0;
		unique case (width_i)
			SFR_W_SINGLE: begin
				io_o[1] = shift_i[7];
			end
			SFR_W_DUAL: begin
				io_o[1] = shift_i[7];
				io_o[0] = shift_i[6];
			end
			SFR_W_QUAD: begin
				io_o = shift_i[7:4];
			end
			default: begin
				io_o = 4'h0;
			end
		endcase
	end
endmodule

// [src/sfr_pkg.sv]
// types shared by the serial flash array read path
package sfr_pkg;

	// command phase of one device-select frame
	typedef enum logic [2:0] {
		SFR_ST_IDLE,
		SFR_ST_CMD,
		SFR_ST_ADDR,
		SFR_ST_DUMMY,
		SFR_ST_DATA,
		SFR_ST_IGNORE
	} sfr_state_t;

	// number of data lanes used for the read data
	typedef enum logic [1:0] {
		SFR_W_SINGLE,
		SFR_W_DUAL,
		SFR_W_QUAD
	} sfr_width_t;

endpackage

// [src/sfr_read_path.sv]
// read path of the serial flash command decoder, sampled on the core clock
`timescale 1ns/10ps
`include "sfr_regs.svh"
module sfr_read_path
	import sfr_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic [3:0] io_i,
	output logic [3:0] io_o,
	output logic [3:0] io_oe_o,
	input wire logic four_lane_enable_bit_i,
	input wire logic word_aligned_addressing_i,
	input wire logic [3:0] xip_dummy_clks_i,
	output logic [`SFR_ARRAY_AW-1:0] mem_addr_o,
	input wire logic [7:0] mem_data_i,
	output logic execute_in_place_read_o
);
	import sfr_pkg::*;

	logic rst_meta_reg;
	logic rst_core_n_reg;
	logic [5:0] pins_s;
	logic cs_n_s;
	logic sck_s;
	logic [3:0] io_s;
	logic sck_d_reg;
	logic sck_rise;
	logic sck_fall;

	sfr_state_t state_reg, state_next;
	sfr_width_t width_reg, width_next;
	logic [4:0] cnt_reg, cnt_next;
	logic [3:0] dummy_len_reg, dummy_len_next;
	logic [7:0] cmd_sh_reg, cmd_sh_next;
	logic [23:0] addr_sh_reg, addr_sh_next;
	logic [`SFR_ARRAY_AW-1:0] addr_reg, addr_next;
	logic [3:0] mode_reg, mode_next;
	logic quad_addr_reg, quad_addr_next;
	logic aligned_reg, aligned_next;
	logic slow_reg, slow_next;
	logic xip_reg, xip_next;
	logic xip_aligned_reg, xip_aligned_next;
	logic [7:0] out_sh_reg, out_sh_next;
	logic [2:0] beat_reg, beat_next;
	logic [3:0] oe_reg, oe_next;

	logic [7:0] opcode;
	logic [23:0] addr_full;
	logic [7:0] mode_full;
	logic [3:0] dummy_quad;

	// release of the asynchronous reset passes two flops
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_reg <= 1'b0;
			rst_core_n_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_core_n_reg <= rst_meta_reg;
		end
	end

	// select, clock and data pins all come from the host's domain;
	// select goes in inverted so the cleared flops read as deselected
	sfr_sync #(
		.WIDTH(6)
	) u_pin_sync (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_core_n_reg),
		.d_i({~cs_n_i, sck_i, io_i}),
		.q_o(pins_s)
	);

	assign cs_n_s = ~pins_s[5];
	assign sck_s = pins_s[4];
	assign io_s = pins_s[3:0];

	// serial clock edges found on the synchronised copy
	always_ff @(posedge core_clk_i or negedge rst_core_n_reg) begin
		if (!rst_core_n_reg) begin
			sck_d_reg <= 1'b0;
		end else begin
			sck_d_reg <= sck_s;
		end
	end

	assign sck_rise = sck_s & ~sck_d_reg;
	assign sck_fall = ~sck_s & sck_d_reg;

	// helpers read by the phase logic below
	assign opcode = {cmd_sh_reg[6:0], io_s[0]};
	assign addr_full = quad_addr_reg ? {addr_sh_reg[19:0], io_s} :
		{addr_sh_reg[22:0], io_s[0]};
	assign mode_full = {mode_reg, io_s};
	// the mode field needs two clocks, so shorter settings are raised to two
	assign dummy_quad = (xip_dummy_clks_i < `SFR_MODE_CLKS) ?
		`SFR_MODE_CLKS : xip_dummy_clks_i;

	// next state of the frame: sampling on rising, shifting out on falling
	always_comb begin
		state_next = state_reg;
		width_next = width_reg;
		cnt_next = cnt_reg;
		dummy_len_next = dummy_len_reg;
		cmd_sh_next = cmd_sh_reg;
		addr_sh_next = addr_sh_reg;
		addr_next = addr_reg;
		mode_next = mode_reg;
		quad_addr_next = quad_addr_reg;
		aligned_next = aligned_reg;
		slow_next = slow_reg;
		xip_next = xip_reg;
		xip_aligned_next = xip_aligned_reg;
		out_sh_next = out_sh_reg;
		beat_next = beat_reg;
		oe_next = oe_reg;
		if (cs_n_s) begin
			// select high ends any read mid-byte and floats every pin
			state_next = SFR_ST_IDLE;
			cnt_next = 5'd0;
			beat_next = 3'd0;
			oe_next = 4'h0;
		end else begin
			unique case (state_reg)
				SFR_ST_IDLE: begin
					cnt_next = 5'd0;
					if (xip_reg) begin
						// armed by the last mode field: skip the opcode
						state_next = SFR_ST_ADDR;
						quad_addr_next = 1'b1;
						width_next = SFR_W_QUAD;
						aligned_next = xip_aligned_reg;
						dummy_len_next = dummy_quad;
					end else begin
						state_next = SFR_ST_CMD;
					end
				end
				SFR_ST_CMD: begin
					if (sck_rise) begin
						cmd_sh_next = opcode;
						cnt_next = cnt_reg + 5'd1;
						if (cnt_reg == `SFR_CMD_LAST) begin
							cnt_next = 5'd0;
							state_next = SFR_ST_ADDR;
							quad_addr_next = 1'b0;
							aligned_next = 1'b0;
							slow_next = 1'b0;
							dummy_len_next = `SFR_DUMMY_BYTE_CLKS;
							unique case (opcode)
								`SFR_OP_READ_SLOW: begin
									width_next = SFR_W_SINGLE;
									slow_next = 1'b1;
								end
								`SFR_OP_READ_FAST: begin
									width_next = SFR_W_SINGLE;
								end
								`SFR_OP_READ_DUAL: begin
									width_next = SFR_W_DUAL;
								end
								`SFR_OP_READ_QUAD: begin
									width_next = SFR_W_QUAD;
									if (!four_lane_enable_bit_i) begin
										state_next = SFR_ST_IGNORE;
									end
								end
								`SFR_OP_READ_QADDR: begin
									width_next = SFR_W_QUAD;
									quad_addr_next = 1'b1;
									aligned_next = word_aligned_addressing_i;
									dummy_len_next = dummy_quad;
								end
								`SFR_OP_READ_QWORD: begin
									width_next = SFR_W_QUAD;
									quad_addr_next = 1'b1;
									aligned_next = 1'b1;
									dummy_len_next = dummy_quad;
								end
								default: begin
									// commands outside the read path are left alone
									state_next = SFR_ST_IGNORE;
								end
							endcase
						end
					end
				end
				SFR_ST_ADDR: begin
					if (sck_rise) begin
						addr_sh_next = addr_full;
						cnt_next = cnt_reg + 5'd1;
						if (cnt_reg == (quad_addr_reg ? `SFR_QADDR_LAST :
							`SFR_ADDR_LAST)) begin
							cnt_next = 5'd0;
							// only the low bits index the 4M byte array
							addr_next = addr_full[`SFR_ARRAY_AW-1:0];
							if (aligned_reg) begin
								addr_next[1:0] = 2'b00;
							end
							state_next = slow_reg ? SFR_ST_DATA :
								SFR_ST_DUMMY;
						end
					end
				end
				SFR_ST_DUMMY: begin
					if (sck_rise) begin
						cnt_next = cnt_reg + 5'd1;
						if (quad_addr_reg && cnt_reg < 5'd2) begin
							mode_next = io_s;
						end
						if (quad_addr_reg && cnt_reg == 5'd1) begin
							xip_next = mode_full[`SFR_MODE_KEEP_HI:
								`SFR_MODE_KEEP_LO] == `SFR_MODE_KEEP;
							xip_aligned_next = aligned_reg;
						end
						if (cnt_reg == {1'b0, dummy_len_reg - 4'd1}) begin
							cnt_next = 5'd0;
							state_next = SFR_ST_DATA;
						end
					end
				end
				SFR_ST_DATA: begin
					if (sck_fall) begin
						// pins turn to outputs on the first data edge
						unique case (width_reg)
							SFR_W_SINGLE: oe_next = 4'b0010;
							SFR_W_DUAL: oe_next = 4'b0011;
							default: oe_next = 4'b1111;
						endcase
						if (beat_reg == 3'd0) begin
							// next byte already read; address wraps to 0 after the last address
							out_sh_next = mem_data_i;
							addr_next = (addr_reg == `SFR_LAST_ADDR) ?
								'0 : addr_reg + 1'b1;
						end else begin
							unique case (width_reg)
								SFR_W_SINGLE: out_sh_next = {out_sh_reg[6:0], 1'b0};
								SFR_W_DUAL: out_sh_next = {out_sh_reg[5:0], 2'b00};
								default: out_sh_next = {out_sh_reg[3:0], 4'h0};
							endcase
						end
						unique case (width_reg)
							SFR_W_SINGLE: beat_next = beat_reg + 3'd1;
							SFR_W_DUAL: beat_next = {1'b0, beat_reg[1:0] + 2'd1};
							default: beat_next = {2'b00, ~beat_reg[0]};
						endcase
					end
				end
				SFR_ST_IGNORE: begin
					oe_next = 4'h0;
				end
			endcase
		end
	end

	// frame state registers
	always_ff @(posedge core_clk_i or negedge rst_core_n_reg) begin
		if (!rst_core_n_reg) begin
			state_reg <= SFR_ST_IDLE;
			width_reg <= SFR_W_SINGLE;
			cnt_reg <= 5'd0;
			dummy_len_reg <= 4'd0;
			cmd_sh_reg <= 8'h00;
			addr_sh_reg <= 24'h000000;
			addr_reg <= '0;
			mode_reg <= 4'h0;
			quad_addr_reg <= 1'b0;
			aligned_reg <= 1'b0;
			slow_reg <= 1'b0;
			xip_reg <= 1'b0;
			xip_aligned_reg <= 1'b0;
			out_sh_reg <= 8'h00;
			beat_reg <= 3'd0;
			oe_reg <= 4'h0;
		end else begin
			state_reg <= state_next;
			width_reg <= width_next;
			cnt_reg <= cnt_next;
			dummy_len_reg <= dummy_len_next;
			cmd_sh_reg <= cmd_sh_next;
			addr_sh_reg <= addr_sh_next;
			addr_reg <= addr_next;
			mode_reg <= mode_next;
			quad_addr_reg <= quad_addr_next;
			aligned_reg <= aligned_next;
			slow_reg <= slow_next;
			xip_reg <= xip_next;
			xip_aligned_reg <= xip_aligned_next;
			out_sh_reg <= out_sh_next;
			beat_reg <= beat_next;
			oe_reg <= oe_next;
		end
	end

	// data pins are a plain mux of flops to save a cycle of output delay
	sfr_lane_mux u_lane_mux (
		.width_i(width_reg),
		.shift_i(out_sh_reg),
		.io_o(io_o)
	);

	assign io_oe_o = oe_reg;
	assign mem_addr_o = addr_reg;
	assign execute_in_place_read_o = xip_reg;
endmodule

// [src/sfr_regs.svh]
// constants of the serial flash array read path
`ifndef SFR_REGS_SVH
`define SFR_REGS_SVH

// command opcodes
`define SFR_OP_READ_SLOW 8'h03
`define SFR_OP_READ_FAST 8'h0b
`define SFR_OP_READ_DUAL 8'h3b
`define SFR_OP_READ_QUAD 8'h6b
`define SFR_OP_READ_QADDR 8'heb
`define SFR_OP_READ_QWORD 8'he7

// phase lengths in serial clocks: command and address as last index from zero, dummy and mode as counts
`define SFR_CMD_LAST 5'd7
`define SFR_ADDR_LAST 5'd23
`define SFR_QADDR_LAST 5'd5
`define SFR_DUMMY_BYTE_CLKS 4'd8
`define SFR_MODE_CLKS 4'd2

// mode field value that keeps the opcode-less read armed
`define SFR_MODE_KEEP 2'b10
`define SFR_MODE_KEEP_HI 5
`define SFR_MODE_KEEP_LO 4

// array geometry: 4M bytes, last address 3fffff
`define SFR_ARRAY_AW 22
`define SFR_LAST_ADDR 22'h3fffff

`endif

// [src/sfr_sync.sv]
// two flip-flop synchroniser for pins outside the core clock domain
`timescale 1ns/10ps
module sfr_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// first stage feeds only the second stage
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= d_i;
			sync_reg <= meta_reg;
		end
	end

	assign q_o = sync_reg;
endmodule
